// >>> verilog/evt_map.svh
// Purpose: Constants for the exception and vector-table block.
// Assumes: 32-bit addresses, one 32-bit word per table entry.
// Notes: Included by its bare name.
`ifndef EVT_MAP_SVH
`define EVT_MAP_SVH
// ----------------------------------------------------------------------------
// Table layout
// ----------------------------------------------------------------------------
`define EVT_BASE_RESET 32'h0000_0000
`define EVT_BASE_MIN 32'h0000_0200
`define EVT_BASE_MAX 32'h3fff_fe00
`define EVT_BASE_ALIGN_MASK 32'h0000_01ff
`define EVT_IRQ_VEC_FIRST 8'h10
`define EVT_IRQ_OFFSET_FIRST 32'h0000_0040
// ----------------------------------------------------------------------------
// Vector numbers
// ----------------------------------------------------------------------------
`define EVT_VEC_STACK 8'h00
`define EVT_VEC_RESET 8'h01
`define EVT_VEC_NMI 8'h02
`define EVT_VEC_HARD 8'h03
`define EVT_VEC_BUS 8'h05
`define EVT_VEC_CORE_LAST 8'h0f
`define EVT_IRQ_PORT_Q 8'h7c
`define EVT_IRQ_PORT_R 8'h84
`define EVT_IRQ_PORT_S 8'h85
`define EVT_IRQ_RSV_LO 8'h7d
`define EVT_IRQ_RSV_HI 8'h83
// ----------------------------------------------------------------------------
// Peripheral select codes
// ----------------------------------------------------------------------------
`define EVT_SEL_DMA_LAST 3'h5
// ----------------------------------------------------------------------------
// Priorities
// ----------------------------------------------------------------------------
`define EVT_PRIO_RESET 4'hd
`define EVT_PRIO_NMI 4'he
`define EVT_PRIO_HARD 4'hf
`define EVT_PRIO_DEFAULT 4'h0
`endif

// >>> verilog/evt_pkg.sv
// Purpose: Types for the exception and vector-table block.
// Assumes: Nothing beyond the map header.
// Notes: Priorities are signed four-bit values.
package evt_pkg;
  typedef enum logic [1:0] {EVT_ST_RESET, EVT_ST_STACK, EVT_ST_VEC, EVT_ST_RUN} evt_state_e;
  typedef logic signed [3:0] evt_prio_t;
endpackage : evt_pkg

// >>> verilog/evt_sync.sv
// Purpose: Three-stage synchroniser with agreement of the last two stages.
// Assumes: Input is asynchronous to clk_i.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ns
`default_nettype none
module evt_sync (
  input wire logic clk_i,    // System clock.
  input wire logic rst_n_i,  // Synchronous reset, active low.
  input wire logic async_i,  // Asynchronous level.
  output logic level_o       // Filtered level.
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // A change is taken only once the second and third stages agree.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule : evt_sync
`default_nettype wire

// >>> verilog/evt_vector_table.sv
// Purpose: Exception selection, vector-table base and handler fetch address.
// Assumes: Core fetch requests are on clk_i; fault pins other than the hard and precise faults are asynchronous.
// Notes: One table entry is one 32-bit word.
`timescale 1ns/1ns
`default_nettype none
`include "evt_map.svh"
module evt_vector_table (
  input wire logic clk_i,                // System clock, 20 MHz.
  input wire logic rst_n_i,              // Synchronous reset, active low.
  input wire logic vtor_wr_i,            // Table offset register write strobe.
  input wire logic vtor_priv_i,          // Write is privileged.
  input wire logic [31:0] vtor_wdata_i,  // New table base.
  input wire logic [133:0] irq_i,        // Peripheral interrupt levels.
  input wire logic hard_fault_i,         // Hard fault from the core.
  input wire logic precise_fault_i,      // Precise bus fault, synchronous.
  input wire logic clock_fail_i,         // Clock-fail detect, asynchronous.
  input wire logic expansion_err_i,      // Expansion block error, asynchronous.
  input wire logic host_pin_input_i,     // External NMI pin, asynchronous.
  input wire logic imprecise_fault_i,    // Imprecise access error, asynchronous.
  input wire logic ram_uncorr_i,         // Uncorrectable RAM error, asynchronous.
  input wire logic flash_uncorr_i,       // Uncorrectable flash error, asynchronous.
  input wire logic software_reset_request_i, // Software reset from the controller.
  input wire logic fetch_done_i,         // Core has taken the fetch address.
  input wire logic dma_master_i,         // Current peripheral access is by DMA.
  input wire logic [2:0] periph_sel_i,   // 0 crc,1-2 wdog,3 nmi wdog,4 can,5 i2c,6 other.
  output logic [31:0] fetch_addr_o,      // Byte address of the entry to fetch.
  output logic fetch_valid_o,            // Fetch address is valid.
  output logic stack_fetch_o,            // Current fetch is the stack pointer.
  output logic [7:0] vector_o,           // Vector being fetched.
  output logic signed [3:0] prio_o,      // Priority of that vector.
  output logic [31:0] vector_table_offset_reg_o, // Current base.
  output logic nonmaskable_event_o,      // NMI pending level.
  output logic bus_fault_o,              // Bus fault pending level.
  output logic [1:0] watchdog_reset_requests_o, // One request per watchdog.
  output logic nmi_watchdog_reset_request_o,    // NMI watchdog reset request.
  output logic periph_grant_o            // Peripheral access allowed.
);
  evt_pkg::evt_state_e state_r;
  logic [31:0] base_r;
  logic clk_fail_s;
  logic exp_err_s;
  logic pin_nmi_s;
  logic impr_s;
  logic ram_s;
  logic flash_s;
  logic nmi_cause;
  logic bus_cause;
  logic [7:0] vec_nxt;
  logic [7:0] vec_d;
  logic base_wr_ok;
  logic found;
  logic [7:0] irq_vec [0:133];

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  evt_sync u_sync_cf (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(clock_fail_i),
    .level_o(clk_fail_s));
  evt_sync u_sync_ex (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(expansion_err_i),
    .level_o(exp_err_s));
  evt_sync u_sync_pn (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(host_pin_input_i),
    .level_o(pin_nmi_s));
  evt_sync u_sync_im (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(imprecise_fault_i),
    .level_o(impr_s));
  evt_sync u_sync_rm (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(ram_uncorr_i),
    .level_o(ram_s));
  evt_sync u_sync_fl (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(flash_uncorr_i),
    .level_o(flash_s));

  // --------------------------------------------------------------------------
  // Fault sources
  // --------------------------------------------------------------------------
  // The NMI watchdog timeout feeds back as an NMI cause.
  assign nmi_cause = clk_fail_s | exp_err_s | pin_nmi_s | nmi_watchdog_reset_request_o;
  assign bus_cause = precise_fault_i | impr_s | ram_s | flash_s;

  // Pending levels for NMI and bus fault.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      nonmaskable_event_o <= 1'b0;
      bus_fault_o <= 1'b0;
    end else begin
      nonmaskable_event_o <= nmi_cause;
      bus_fault_o <= bus_cause;
    end
  end

  // Watchdog reset paths; the NMI watchdog fires on a held NMI event.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      watchdog_reset_requests_o <= 2'h0;
      nmi_watchdog_reset_request_o <= 1'b0;
    end else begin
      watchdog_reset_requests_o <= {2{software_reset_request_i}};
      nmi_watchdog_reset_request_o <= nonmaskable_event_o & nmi_cause;
    end
  end

  // --------------------------------------------------------------------------
  // Table base
  // --------------------------------------------------------------------------
  // Unaligned or out-of-range writes are dropped so the base stays usable.
  assign base_wr_ok = vtor_wr_i && vtor_priv_i && vtor_wdata_i >= `EVT_BASE_MIN
                      && vtor_wdata_i <= `EVT_BASE_MAX
                      && (vtor_wdata_i & `EVT_BASE_ALIGN_MASK) == 32'h0;

  // Table base register.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      base_r <= `EVT_BASE_RESET;
    end else if (base_wr_ok) begin
      base_r <= vtor_wdata_i;
    end
  end
  assign vector_table_offset_reg_o = base_r;

  // --------------------------------------------------------------------------
  // Interrupt vector map
  // --------------------------------------------------------------------------
  // Each interrupt bit maps to its vector; reserved bits map to zero.
  for (genvar g = 0; g < 134; g++) begin : g_irq
    assign irq_vec[g] = (8'(g) >= `EVT_IRQ_RSV_LO && 8'(g) <= `EVT_IRQ_RSV_HI) ? 8'h00
                        : 8'(g) + `EVT_IRQ_VEC_FIRST;
  end

  // Highest-priority source: NMI, hard fault, bus fault, then lowest irq bit.
  always_comb begin
    vec_nxt = 8'h00;
    found = 1'b0;
    if (nonmaskable_event_o) begin
      vec_nxt = `EVT_VEC_NMI;
      found = 1'b1;
    end else if (hard_fault_i) begin
      vec_nxt = `EVT_VEC_HARD;
      found = 1'b1;
    end else if (bus_fault_o) begin
      vec_nxt = `EVT_VEC_BUS;
      found = 1'b1;
    end else begin
      for (int i = 133; i >= 0; i--) begin
        if (irq_i[i] && irq_vec[i] != 8'h00) begin
          vec_nxt = irq_vec[i];
          found = 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Fetch sequencer
  // --------------------------------------------------------------------------
  // Reset always goes stack first, then the reset vector.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r <= evt_pkg::EVT_ST_RESET;
      fetch_valid_o <= 1'b0;
      stack_fetch_o <= 1'b0;
    end else begin
      case (state_r)
        evt_pkg::EVT_ST_RESET: begin
          state_r <= evt_pkg::EVT_ST_STACK;
          fetch_valid_o <= 1'b1;
          stack_fetch_o <= 1'b1;
        end
        evt_pkg::EVT_ST_STACK: begin
          if (fetch_done_i) begin
            state_r <= evt_pkg::EVT_ST_VEC;
            stack_fetch_o <= 1'b0;
          end
        end
        evt_pkg::EVT_ST_VEC: begin
          if (fetch_done_i) begin
            state_r <= evt_pkg::EVT_ST_RUN;
            fetch_valid_o <= 1'b0;
          end
        end
        default: begin
          if (found && !fetch_valid_o) begin
            fetch_valid_o <= 1'b1;
          end else if (fetch_done_i) begin
            fetch_valid_o <= 1'b0;
          end
        end
      endcase
    end
  end

  // Next vector, worked out ahead so that address and priority register with it.
  always_comb begin
    vec_d = vector_o;
    case (state_r)
      evt_pkg::EVT_ST_RESET: begin
        vec_d = `EVT_VEC_STACK;
      end
      evt_pkg::EVT_ST_STACK: begin
        if (fetch_done_i) begin
          vec_d = `EVT_VEC_RESET;
        end
      end
      evt_pkg::EVT_ST_VEC: begin
        vec_d = vector_o;
      end
      default: begin
        if (found && !fetch_valid_o) begin
          vec_d = vec_nxt;
        end
      end
    endcase
  end

  // Vector, address and priority are registered together; the address also
  // follows a relocation at once, so it never points into a stale table.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      vector_o <= `EVT_VEC_STACK;
      fetch_addr_o <= `EVT_BASE_RESET;
      prio_o <= `EVT_PRIO_DEFAULT;
    end else begin
      vector_o <= vec_d;
      fetch_addr_o <= (base_wr_ok ? vtor_wdata_i : base_r) + {22'h0, vec_d, 2'b00};
      case (vec_d)
        `EVT_VEC_RESET: prio_o <= `EVT_PRIO_RESET;
        `EVT_VEC_NMI: prio_o <= `EVT_PRIO_NMI;
        `EVT_VEC_HARD: prio_o <= `EVT_PRIO_HARD;
        default: prio_o <= `EVT_PRIO_DEFAULT;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Peripheral access filter
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      periph_grant_o <= 1'b0;
    end else begin
      periph_grant_o <= !(dma_master_i && periph_sel_i <= `EVT_SEL_DMA_LAST);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  stack_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(fetch_valid_o) && $past(state_r) == evt_pkg::EVT_ST_RESET |-> stack_fetch_o)
    else $error("Stack pointer not fetched first.");
  base_reset_a: assert property (@(posedge clk_i)
    !rst_n_i |=> base_r == `EVT_BASE_RESET) else $error("Base not zero after reset.");
  base_guard_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    vtor_wr_i && !vtor_priv_i |=> $stable(base_r)) else $error("Unprivileged base write.");
  addr_form_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fetch_addr_o[1:0] == 2'b00 && fetch_addr_o - base_r == {22'h0, vector_o, 2'b00})
    else $error("Fetch address wrong.");
  nmi_prio_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    vector_o == `EVT_VEC_NMI |-> prio_o == `EVT_PRIO_NMI) else $error("NMI priority wrong.");
  nmi_src_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    nmi_cause |=> nonmaskable_event_o) else $error("NMI not raised.");
  wdog_rst_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    software_reset_request_i |=> watchdog_reset_requests_o == 2'h3)
    else $error("Watchdog reset lines not driven.");
  dma_deny_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dma_master_i && periph_sel_i == 3'h0 |=> !periph_grant_o) else $error("DMA reached CRC.");
  port_q_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_vec[`EVT_IRQ_PORT_Q] == 8'h8c && irq_vec[`EVT_IRQ_PORT_R] == 8'h94)
    else $error("Port vectors wrong.");
  boot_c: cover property (@(posedge clk_i) state_r == evt_pkg::EVT_ST_RUN);
  reloc_c: cover property (@(posedge clk_i) base_r != `EVT_BASE_RESET);
  nmi_c: cover property (@(posedge clk_i) fetch_valid_o && vector_o == `EVT_VEC_NMI);
endmodule : evt_vector_table
`default_nettype wire

// >>> verif/evt_core_model.sv
// Purpose: Behavioural core that takes the handler fetches the block offers.
// Assumes: One fetch at a time, taken with a one-cycle done pulse.
// Notes: delay_i lets a test make the core slow to answer.
`timescale 1ns/1ns
`default_nettype none
module evt_core_model (
  input wire logic clk_i,         // System clock.
  input wire logic rst_n_i,       // Synchronous reset, active low.
  input wire logic fetch_valid_i, // Fetch address offered.
  input wire logic [3:0] delay_i, // Cycles to wait before taking.
  output logic done_o             // Fetch taken, one cycle.
);
  // --------------------------------------------------------------------------
  // Take logic
  // --------------------------------------------------------------------------
  logic [3:0] wait_r;

  // A cycle is skipped after each take, so that one offer is never taken twice.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      done_o <= 1'h0;
      wait_r <= 4'h0;
    end else if (done_o) begin
      done_o <= 1'h0;
      wait_r <= 4'h0;
    end else if (fetch_valid_i && wait_r >= delay_i) begin
      done_o <= 1'h1;
    end else if (fetch_valid_i) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : evt_core_model
`default_nettype wire

// >>> verif/tb.sv
// Purpose: Self-checking bench for the exception and vector-table block.
// Assumes: 20 MHz clock, synchronous active-low reset.
// Notes: Each test reboots the block so that pending levels never leak.
`timescale 1ns/1ns
`default_nettype none
module tb;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic vtor_wr_i = 1'h0;
  logic vtor_priv_i = 1'h0;
  logic [31:0] vtor_wdata_i = 32'h0;
  logic [133:0] irq_i = '0;
  logic [7:0] src_r = 8'h0;
  logic software_reset_request_i = 1'h0;
  logic dma_master_i = 1'h0;
  logic [2:0] periph_sel_i = 3'h0;
  logic [3:0] delay_r = 4'h0;
  logic fetch_done_i, fetch_valid_o, stack_fetch_o, nonmaskable_event_o, bus_fault_o;
  logic nmi_watchdog_reset_request_o, periph_grant_o;
  logic [31:0] fetch_addr_o, vector_table_offset_reg_o;
  logic [7:0] vector_o;
  logic signed [3:0] prio_o;
  logic [1:0] watchdog_reset_requests_o;
  logic [63:0] log_q[$];
  int n_mismatch = 0;
  int check_count = 0;

  // Clock at 50 ns period.
  always #25 clk_i = ~clk_i;

  // Fault sources: 0 clock fail, 1 expansion, 2 pin, 3..5 imprecise, ram, flash.
  evt_vector_table dut_u (
    .clk_i, .rst_n_i, .vtor_wr_i, .vtor_priv_i, .vtor_wdata_i, .irq_i,
    .hard_fault_i(src_r[6]), .precise_fault_i(src_r[7]), .clock_fail_i(src_r[0]),
    .expansion_err_i(src_r[1]), .host_pin_input_i(src_r[2]), .imprecise_fault_i(src_r[3]),
    .ram_uncorr_i(src_r[4]), .flash_uncorr_i(src_r[5]), .software_reset_request_i,
    .fetch_done_i, .dma_master_i, .periph_sel_i, .fetch_addr_o, .fetch_valid_o,
    .stack_fetch_o, .vector_o, .prio_o, .vector_table_offset_reg_o, .nonmaskable_event_o,
    .bus_fault_o, .watchdog_reset_requests_o, .nmi_watchdog_reset_request_o, .periph_grant_o
  );
  evt_core_model core_u (.clk_i, .rst_n_i, .fetch_valid_i(fetch_valid_o),
    .delay_i(delay_r), .done_o(fetch_done_i));

  // Every fetch the core takes is logged mid-cycle, before the edge that takes it,
  // so that a task waking on that edge always sees the entry already there.
  always @(negedge clk_i) begin
    if (fetch_done_i && fetch_valid_o)
      log_q.push_back({19'h0, stack_fetch_o, prio_o, vector_o, fetch_addr_o});
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  function automatic logic [63:0] ent(input logic s, input logic [3:0] p,
      input logic [7:0] v, input logic [31:0] a);
    return {19'h0, s, p, v, a};
  endfunction : ent

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // Bounded wait, so a missing fetch shows as a mismatch rather than a hang.
  task automatic wait_log(input int n);
    for (int i = 0; i < 40 && log_q.size() < n; i++) @(posedge clk_i);
  endtask : wait_log

  task automatic boot(input logic [3:0] d);
    delay_r <= d;
    rst_n_i <= 1'h0;
    repeat (5) @(posedge clk_i);
    log_q.delete();
    rst_n_i <= 1'h1;
    wait_log(2);
  endtask : boot

  task automatic wr(input logic p, input logic [31:0] d, input logic [31:0] e);
    vtor_wr_i <= 1'h1;
    vtor_priv_i <= p;
    vtor_wdata_i <= d;
    @(posedge clk_i);
    vtor_wr_i <= 1'h0;
    @(posedge clk_i);
    chk({32'h0, vector_table_offset_reg_o}, {32'h0, e});
  endtask : wr

  task automatic irq(input int n, input logic [7:0] v, input logic [31:0] a);
    int k;
    k = log_q.size();
    irq_i[n] <= 1'h1;
    wait_log(k + 1);
    irq_i[n] <= 1'h0;
    chk(log_q[k], ent(1'h0, 4'h0, v, a));
    repeat (6) @(posedge clk_i);
  endtask : irq

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  task automatic t_boot();
    boot(4'h3);
    chk(log_q[0], ent(1'h1, 4'h0, 8'h00, 32'h0));
    chk(log_q[1], ent(1'h0, 4'hd, 8'h01, 32'h4));
    repeat (3) @(posedge clk_i);
    chk({63'h0, fetch_valid_o}, 64'h0);
    $display("test boot done");
  endtask : t_boot

  task automatic t_vtor();
    boot(4'h0);
    wr(1'h0, 32'h0000_0200, 32'h0);
    wr(1'h1, 32'h0000_0201, 32'h0);
    wr(1'h1, 32'h0000_0200, 32'h0000_0200);
    wr(1'h1, 32'h4000_0000, 32'h0000_0200);
    wr(1'h1, 32'h0000_0000, 32'h0000_0200);
    wr(1'h1, 32'h3fff_fe00, 32'h3fff_fe00);
    irq(0, 8'h10, 32'h3fff_fe40);
    $display("test table base done");
  endtask : t_vtor

  task automatic t_irq();
    boot(4'h1);
    irq(124, 8'h8c, 32'h0000_0230);
    irq(132, 8'h94, 32'h0000_0250);
    irq(133, 8'h95, 32'h0000_0254);
    irq_i[131:125] <= 7'h7f;
    repeat (20) @(posedge clk_i);
    chk(64'(log_q.size()), 64'h5);
    irq_i[131:125] <= 7'h00;
    $display("test interrupts done");
  endtask : t_irq

  // Holds one fault source, then checks the fetch and which levels were raised.
  task automatic t_src(input int i, input logic [7:0] v, input logic [3:0] p,
      input logic [2:0] f);
    logic [2:0] seen;
    boot(4'h2);
    seen = 3'h0;
    src_r[i] <= 1'h1;
    repeat (30) begin
      @(posedge clk_i);
      seen |= {nonmaskable_event_o, bus_fault_o, nmi_watchdog_reset_request_o};
    end
    src_r[i] <= 1'h0;
    chk(log_q[2], ent(1'h0, p, v, {22'h0, v, 2'h0}));
    chk({61'h0, seen}, {61'h0, f});
    $display("test fault source %0d done", i);
  endtask : t_src

  task automatic t_misc();
    boot(4'h0);
    software_reset_request_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    chk({62'h0, watchdog_reset_requests_o}, 64'h3);
    software_reset_request_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    chk({62'h0, watchdog_reset_requests_o}, 64'h0);
    for (int s = 0; s < 16; s++) begin
      dma_master_i <= s[3];
      periph_sel_i <= s[2:0];
      repeat (2) @(posedge clk_i);
      chk({63'h0, periph_grant_o}, {63'h0, !s[3] || s[2:0] > 5});
    end
    $display("test watchdog and access done");
  endtask : t_misc

  // Main sequence.
  initial begin
    t_boot();
    t_vtor();
    t_irq();
    for (int i = 0; i < 3; i++) t_src(i, 8'h02, 4'he, 3'h5);
    for (int i = 3; i < 6; i++) t_src(i, 8'h05, 4'h0, 3'h2);
    t_src(7, 8'h05, 4'h0, 3'h2);
    t_src(6, 8'h03, 4'hf, 3'h0);
    t_misc();
    end_of_test();
  end

  // The tests need about 600 cycles; 4000 cycles means something hung.
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
